/* File: core/foc_pkg.sv */
// package for the option-control register block: offsets, field positions, reset values, carriers
// assumes a single core clock and a synchronous active-high reset
package foc_pkg;

    localparam logic [7:0]  FOC_OPTION_CODE      = 8'hE5;
    localparam logic [7:0]  FOC_PHASE_SYNC_CODE  = 8'hE6;
    localparam logic [15:0] FOC_OPTION_RESET     = 16'h7F00;
    localparam logic [15:0] FOC_PHASE_SYNC_RESET = 16'h0000;

    // option byte field positions (upper byte of option_control)
    localparam int FOC_ADC_EN_BIT   = 2;
    localparam int FOC_TPFE_BIT     = 1;
    localparam int FOC_PSM_BIT      = 0;
    // alert byte field positions (lower byte of option_control)
    localparam int FOC_OVONLY_BIT   = 1;
    localparam int FOC_MASK_BIT     = 0;
    // saved-image position of the page one mask bit
    localparam int FOC_NVM_MASK1_BIT = 2;

    localparam logic [7:0]  FOC_OPT_HI_RESET  = 8'h7F;
    localparam logic        FOC_OVONLY_RESET  = 1'b0;
    localparam logic [1:0]  FOC_MASK_RESET    = 2'b00;

    // register request from the management bus front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        page;
        logic [7:0]  code;
        logic [15:0] wdata;
    } foc_req_s;

    // per-channel fault evidence from the analog side
    typedef struct packed {
        logic ov;
        logic other;
        logic above_stage;
        logic above_ot;
    } foc_fault_s;

    // whole state of the register block
    typedef struct packed {
        logic [7:0]  opt_hi;
        logic        ovonly;
        logic [1:0]  mask;
        logic [15:0] phase;
        logic        psm_active;
        logic [15:0] rdata;
        logic        rvalid;
        logic        alert;
        logic [1:0]  psf;
        logic [1:0]  ot;
        logic [15:0] meas;
        logic        nvm_wr;
    } foc_state_s;

endpackage

/* File: core/foc_alert_gate.sv */
// per-page alert gate: turns one page's fault sources into an alert request
// assumes stage fault, ov-only and mask are registered state; overvoltage and other arrive unregistered
`timescale 1ns/10ps
module foc_alert_gate (
    input  wire logic ov_in,
    input  wire logic other_in,
    input  wire logic stage_fault_in,
    input  wire logic ovonly_in,
    input  wire logic mask_in,
    output logic      alert_req_out
);
    always_comb begin
        if (ovonly_in) begin
            alert_req_out = ov_in;
        end else begin
            alert_req_out = ov_in | other_in | (stage_fault_in & ~mask_in);
        end
    end
endmodule // foc_alert_gate

/* File: core/foc_option_regs.sv */
// option-control and phase-sync registers with fault qualification and alert shaping
// assumes a register front end decoding the management bus, and an external nonvolatile store
// What this block does
// - the adc run enable resets to one and stops or lets conversion run as written.
// - with temp pin fault enable set, a sense input above the stage level raises stage fault and over-temperature.
// - with temp pin fault enable clear, stage fault is ignored and only over-temperature is raised.
// - over-temperature is always raised when the sense voltage passes the programmed threshold.
// - power stage mode enable resets to one and selects the smart stage interface conventions.
// - a new power stage mode value acts only after save and power-down reboot.
// - restore all defaults leaves the active power stage mode untouched.
// - writes to read-only bits, alert byte bits 7:2 included, are discarded.
// - alert overvoltage only resets to zero and, when set, lets only page zero overvoltage raise the page zero alert request.
// - alert overvoltage only exists for page zero; the page one bit does nothing.
// - the per-page stage fault mask resets to zero and blocks alert from stage fault bits 3 and 2.
// - the phase sync register at E6h resets to 0000h and holds sync and phase settings.
// - saving user configuration changes the power-up value of the phase sync register.
`timescale 1ns/10ps
module foc_option_regs
    import foc_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire foc_req_s    req_in,
    input  wire logic        restore_defaults_in,
    input  wire logic        store_user_in,
    input  wire logic        nvm_valid_in,
    input  wire logic [15:0] nvm_option_in,
    input  wire logic [15:0] nvm_phase_in,
    input  wire foc_fault_s  fault0_in,
    input  wire foc_fault_s  fault1_in,
    input  wire logic        meas_valid_in,
    input  wire logic [15:0] meas_in,
    output logic [15:0]      rdata_out,
    output logic             rvalid_out,
    output logic             adc_enable_out,
    output logic             power_stage_mode_out,
    output logic [15:0]      phase_sync_out,
    output logic [1:0]       power_stage_fault_out,
    output logic [1:0]       ot_fault_out,
    output logic             alert_out,
    output logic [15:0]      meas_out,
    output logic             nvm_wr_out,
    output logic [15:0]      nvm_option_out,
    output logic [15:0]      nvm_phase_out
);
    foc_state_s st_r;
    foc_state_s st_nxt;
    logic [1:0] alert_req;
    logic       tpfe;

    assign tpfe = st_r.opt_hi[FOC_TPFE_BIT];

    foc_alert_gate u_gate0 (
        .ov_in          (fault0_in.ov),
        .other_in       (fault0_in.other),
        .stage_fault_in (st_r.psf[0]),
        .ovonly_in      (st_r.ovonly),
        .mask_in        (st_r.mask[0]),
        .alert_req_out  (alert_req[0])
    );

    foc_alert_gate u_gate1 (
        .ov_in          (fault1_in.ov),
        .other_in       (fault1_in.other),
        .stage_fault_in (st_r.psf[1]),
        .ovonly_in      (1'b0),
        .mask_in        (st_r.mask[1]),
        .alert_req_out  (alert_req[1])
    );

    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.nvm_wr = 1'b0;
        if (srst_in) begin
            // power-up load: saved image when present, else defaults
            if (nvm_valid_in) begin
                st_nxt.opt_hi = nvm_option_in[15:8];
                st_nxt.ovonly = nvm_option_in[FOC_OVONLY_BIT];
                st_nxt.mask   = {nvm_option_in[FOC_NVM_MASK1_BIT], nvm_option_in[FOC_MASK_BIT]};
                st_nxt.phase  = nvm_phase_in;
            end else begin
                st_nxt.opt_hi = FOC_OPT_HI_RESET;
                st_nxt.ovonly = FOC_OVONLY_RESET;
                st_nxt.mask   = FOC_MASK_RESET;
                st_nxt.phase  = FOC_PHASE_SYNC_RESET;
            end
            // active stage mode only changes here, at power-up
            st_nxt.psm_active = nvm_valid_in ? nvm_option_in[8 + FOC_PSM_BIT]
                                             : FOC_OPT_HI_RESET[FOC_PSM_BIT];
            st_nxt.rdata = 16'h0000;
            st_nxt.alert = 1'b0;
            st_nxt.psf   = 2'b00;
            st_nxt.ot    = 2'b00;
            st_nxt.meas  = 16'h0000;
        end else begin
            if (restore_defaults_in) begin
                st_nxt.opt_hi = FOC_OPT_HI_RESET;
                st_nxt.ovonly = FOC_OVONLY_RESET;
                st_nxt.mask   = FOC_MASK_RESET;
                st_nxt.phase  = FOC_PHASE_SYNC_RESET;
            end else if (req_in.wr) begin
                case (req_in.code)
                    FOC_OPTION_CODE: begin
                        st_nxt.opt_hi = req_in.wdata[15:8];
                        if (!req_in.page) begin
                            st_nxt.ovonly = req_in.wdata[FOC_OVONLY_BIT];
                        end
                        st_nxt.mask[req_in.page] = req_in.wdata[FOC_MASK_BIT];
                    end
                    FOC_PHASE_SYNC_CODE: begin
                        st_nxt.phase = req_in.wdata;
                    end
                    default: begin
                        st_nxt.phase = st_r.phase;
                    end
                endcase
            end
            if (store_user_in) begin
                st_nxt.nvm_wr = 1'b1;
            end
            if (req_in.rd) begin
                st_nxt.rvalid = 1'b1;
                case (req_in.code)
                    FOC_OPTION_CODE: begin
                        st_nxt.rdata = {st_r.opt_hi, 6'h00,
                                        st_r.ovonly & ~req_in.page,
                                        st_r.mask[req_in.page]};
                    end
                    FOC_PHASE_SYNC_CODE: begin
                        st_nxt.rdata = st_r.phase;
                    end
                    default: begin
                        st_nxt.rdata = 16'h0000;
                    end
                endcase
            end
            // fault qualification per channel
            st_nxt.psf[0] = tpfe & fault0_in.above_stage;
            st_nxt.psf[1] = tpfe & fault1_in.above_stage;
            st_nxt.ot[0]  = fault0_in.above_stage | fault0_in.above_ot;
            st_nxt.ot[1]  = fault1_in.above_stage | fault1_in.above_ot;
            st_nxt.alert  = |alert_req;
            if (meas_valid_in && st_r.opt_hi[FOC_ADC_EN_BIT]) begin
                st_nxt.meas = meas_in;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        st_r <= st_nxt;
    end

    assign rdata_out             = st_r.rdata;
    assign rvalid_out            = st_r.rvalid;
    assign adc_enable_out        = st_r.opt_hi[FOC_ADC_EN_BIT];
    assign power_stage_mode_out  = st_r.psm_active;
    assign phase_sync_out        = st_r.phase;
    assign power_stage_fault_out = st_r.psf;
    assign ot_fault_out          = st_r.ot;
    assign alert_out             = st_r.alert;
    assign meas_out              = st_r.meas;
    assign nvm_wr_out            = st_r.nvm_wr;
    assign nvm_option_out        = {st_r.opt_hi, 5'h00, st_r.mask[1], st_r.ovonly, st_r.mask[0]};
    assign nvm_phase_out         = st_r.phase;

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    chk_adc_hold: assert property (
        !st_r.opt_hi[FOC_ADC_EN_BIT] && !restore_defaults_in |=> $stable(meas_out))
        else $error("measurement changed while adc disabled");
    chk_psf_raise: assert property (
        tpfe && fault0_in.above_stage |=> power_stage_fault_out[0] && ot_fault_out[0])
        else $error("stage fault or ot missing with pin fault enabled");
    chk_psf_ignore: assert property (
        !tpfe |=> power_stage_fault_out == 2'b00)
        else $error("stage fault raised while pin fault disabled");
    chk_ot_thresh: assert property (
        fault1_in.above_ot |=> ot_fault_out[1])
        else $error("ot fault missing above threshold");
    chk_psm_frozen: assert property (
        !srst_in |=> $stable(power_stage_mode_out))
        else $error("active stage mode changed without power-up");
    chk_ro_bits: assert property (
        rvalid_out && $past(req_in.code) == FOC_OPTION_CODE |-> rdata_out[7:2] == 6'h00)
        else $error("read-only alert bits not zero");
    chk_ovonly_gate: assert property (
        st_r.ovonly && !fault0_in.ov |-> !alert_req[0])
        else $error("page zero alert without overvoltage in ov-only mode");
    chk_page1_ovonly: assert property (
        req_in.wr && req_in.page && req_in.code == FOC_OPTION_CODE && !restore_defaults_in
        |=> $stable(st_r.ovonly))
        else $error("page one write changed ov-only bit");
    chk_mask_gate: assert property (
        st_r.mask[1] && !fault1_in.ov && !fault1_in.other |-> !alert_req[1])
        else $error("masked stage fault raised alert");
    chk_phase_reset: assert property (@(posedge core_clk_in)
        disable iff (1'b0)
        srst_in && !nvm_valid_in |=> phase_sync_out == FOC_PHASE_SYNC_RESET)
        else $error("phase sync not reset to default");
    chk_phase_load: assert property (@(posedge core_clk_in)
        disable iff (1'b0)
        srst_in && nvm_valid_in |=> phase_sync_out == $past(nvm_phase_in))
        else $error("phase sync not loaded from saved image");

    cov_alert: cover property (alert_out);
    cov_psf: cover property (power_stage_fault_out[0]);
    cov_store: cover property (nvm_wr_out);
    cov_adc_off: cover property (!adc_enable_out && meas_valid_in);
endmodule // foc_option_regs

/* File: tb/foc_nvm_model.sv */
// far-side model: nonvolatile store keeping saved images across a power-down
// assumes the bench pulses the reset to stand for the reboot
`timescale 1ns/10ps
module foc_nvm_model (
    input  wire logic        clk_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] option_in,
    input  wire logic [15:0] phase_in,
    output logic             valid_out,
    output logic [15:0]      option_out,
    output logic [15:0]      phase_out
);
    logic [15:0] opt_r;
    logic [15:0] ph_r;
    initial begin
        valid_out = 1'b0;
        opt_r = 16'h0000;
        ph_r = 16'h0000;
    end
    // saved images offered at the next power-up
    always @(posedge clk_in) begin
        if (wr_in) begin
            opt_r <= option_in;
            ph_r <= phase_in;
            valid_out <= 1'b1;
        end
    end
    // no image yet: lines do not show the last value
    assign option_out = valid_out ? opt_r : ~opt_r;
    assign phase_out  = valid_out ? ph_r : ~ph_r;
endmodule // foc_nvm_model

/* File: tb/fault_option_config_bits_bench.sv */
// bench for the option-control register block with a nonvolatile store model
// assumes inputs change at the falling clock edge
`timescale 1ns/10ps
module fault_option_config_bits_bench;
    import foc_pkg::*;
    logic core_clk_in, srst_in, restore_defaults_in, store_user_in, nvm_valid_in;
    logic meas_valid_in, rvalid_out, adc_enable_out, power_stage_mode_out;
    logic alert_out, nvm_wr_out;
    logic [15:0] nvm_option_in, nvm_phase_in, meas_in, rdata_out, phase_sync_out, meas_out;
    logic [15:0] nvm_option_out, nvm_phase_out;
    logic [1:0]  power_stage_fault_out, ot_fault_out;
    foc_req_s    req_in;
    foc_fault_s  fault0_in, fault1_in;
    int          checks = 0;
    int          bad_count = 0;
    int          cyc_cnt = 0;

    foc_option_regs dut_u (.core_clk_in, .srst_in, .req_in, .restore_defaults_in,
        .store_user_in, .nvm_valid_in, .nvm_option_in, .nvm_phase_in, .fault0_in,
        .fault1_in, .meas_valid_in, .meas_in, .rdata_out, .rvalid_out, .adc_enable_out,
        .power_stage_mode_out, .phase_sync_out, .power_stage_fault_out, .ot_fault_out,
        .alert_out, .meas_out, .nvm_wr_out, .nvm_option_out, .nvm_phase_out);
    foc_nvm_model nvm_u (.clk_in(core_clk_in), .wr_in(nvm_wr_out),
        .option_in(nvm_option_out), .phase_in(nvm_phase_out), .valid_out(nvm_valid_in),
        .option_out(nvm_option_in), .phase_out(nvm_phase_in));

    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic reboot;
        srst_in = 1'b1;
        cyc(12);
        srst_in = 1'b0;
    endtask
    task automatic wr(input logic pg, input logic [7:0] code, input logic [15:0] d);
        req_in = '{wr:1'b1, rd:1'b0, page:pg, code:code, wdata:d};
        cyc(1);
        req_in = '0;
        cyc(1);
    endtask
    task automatic rd(input logic pg, input logic [7:0] code, input logic [15:0] e);
        req_in = '{wr:1'b0, rd:1'b1, page:pg, code:code, wdata:16'h0000};
        cyc(1);
        chk({15'h0000, rvalid_out}, 16'h0001);
        chk(rdata_out, e);
        req_in = '0;
        cyc(1);
    endtask
    task automatic pulse_cmd(input logic save);
        if (save) store_user_in = 1'b1;
        else restore_defaults_in = 1'b1;
        cyc(1);
        chk({15'h0000, nvm_wr_out}, {15'h0000, save});
        store_user_in = 1'b0;
        restore_defaults_in = 1'b0;
        cyc(2);
    endtask
    task automatic meas(input logic [15:0] v, input logic [15:0] e);
        meas_in = v;
        meas_valid_in = 1'b1;
        cyc(1);
        meas_valid_in = 1'b0;
        meas_in = ~v;
        cyc(1);
        chk(meas_out, e);
    endtask
    // faults held three cycles, then {psf, ot, alert} compared and faults dropped
    task automatic flt(input logic [3:0] f0, input logic [3:0] f1, input logic [4:0] e);
        fault0_in = f0;
        fault1_in = f1;
        cyc(3);
        chk({11'h000, power_stage_fault_out, ot_fault_out, alert_out}, {11'h000, e});
        fault0_in = '0;
        fault1_in = '0;
        cyc(3);
    endtask

    task automatic t_defaults;
        rd(1'b0, FOC_OPTION_CODE, 16'h7F00);
        rd(1'b1, FOC_OPTION_CODE, 16'h7F00);
        rd(1'b0, FOC_PHASE_SYNC_CODE, 16'h0000);
        chk({14'h0000, adc_enable_out, power_stage_mode_out}, 16'h0003);
        rd(1'b0, 8'hE7, 16'h0000);
    endtask
    task automatic t_readonly;
        wr(1'b0, FOC_OPTION_CODE, 16'hFEFF);
        rd(1'b0, FOC_OPTION_CODE, 16'hFE03);
        chk({15'h0000, power_stage_mode_out}, 16'h0001);
        wr(1'b1, FOC_OPTION_CODE, 16'hFFFF);
        rd(1'b1, FOC_OPTION_CODE, 16'hFF01);
        rd(1'b0, FOC_OPTION_CODE, 16'hFF03);
    endtask
    task automatic t_adc;
        meas(16'h1234, 16'h1234);
        wr(1'b0, FOC_OPTION_CODE, 16'h7B00);
        chk({15'h0000, adc_enable_out}, 16'h0000);
        meas(16'hABCD, 16'h1234);
        wr(1'b0, FOC_OPTION_CODE, 16'h7F00);
        meas(16'hABCD, 16'hABCD);
    endtask
    task automatic t_faults;
        wr(1'b1, FOC_OPTION_CODE, 16'h7F00);
        flt(4'b0010, 4'b0000, 5'b01011);
        flt(4'b0000, 4'b0010, 5'b10101);
        flt(4'b0001, 4'b0000, 5'b00010);
        wr(1'b0, FOC_OPTION_CODE, 16'h7D00);
        flt(4'b0010, 4'b0000, 5'b00010);
        flt(4'b0000, 4'b0001, 5'b00100);
        wr(1'b0, FOC_OPTION_CODE, 16'h7F01);
        flt(4'b0010, 4'b0010, 5'b11111);
        flt(4'b0010, 4'b0000, 5'b01010);
        wr(1'b0, FOC_OPTION_CODE, 16'h7F02);
        flt(4'b0100, 4'b0000, 5'b00000);
        flt(4'b1000, 4'b0000, 5'b00001);
        flt(4'b0010, 4'b0000, 5'b01010);
        flt(4'b0000, 4'b0100, 5'b00001);
    endtask
    task automatic t_save;
        wr(1'b0, FOC_OPTION_CODE, 16'h7E00);
        wr(1'b0, FOC_PHASE_SYNC_CODE, 16'h1234);
        chk(phase_sync_out, 16'h1234);
        chk(nvm_option_out, 16'h7E00);
        chk(nvm_phase_out, 16'h1234);
        pulse_cmd(1'b1);
        pulse_cmd(1'b0);
        chk({15'h0000, power_stage_mode_out}, 16'h0001);
        reboot();
        chk({15'h0000, power_stage_mode_out}, 16'h0000);
        rd(1'b0, FOC_PHASE_SYNC_CODE, 16'h1234);
        rd(1'b0, FOC_OPTION_CODE, 16'h7E00);
        pulse_cmd(1'b0);
        chk({15'h0000, power_stage_mode_out}, 16'h0000);
    endtask

    initial begin
        req_in = '0;
        fault0_in = '0;
        fault1_in = '0;
        meas_valid_in = 1'b0;
        meas_in = 16'h0000;
        restore_defaults_in = 1'b0;
        store_user_in = 1'b0;
        srst_in = 1'b1;
        reboot();
        t_defaults();
        t_readonly();
        t_adc();
        t_faults();
        t_save();
        complete_run();
    end
endmodule // fault_option_config_bits_bench
